// ==== hw/crystal_clock_failure_monitor.sv ====
// Contract
// - High-speed crystal supervision runs only while hs_monitor_enable is set.
// - A detected high-speed crystal failure switches that crystal off without software.
// - A high-speed failure sets hs_stuck_flag and emits a non-maskable failure event.
// - If the failed crystal fed the system clock or PLL, select the 16 MHz RC and stop the PLL.
// - Writing ls_monitor_enable activates low-speed crystal supervision.
// - Low-speed supervision works in every power mode except battery-only mode.
// - A low-speed crystal failure can raise an interrupt request to the CPU.
// - While enabled, a 4-bit up counter runs on the internal 32 kHz RC clock.
// - A low-speed failure is declared when that counter overflows.
module crystal_clock_failure_monitor
    import clock_monitor_pkg::*;
(
    input  wire logic         clock,            // System clock, 20 MHz
    input  wire logic         rst_n,            // Asynchronous reset, active low
    // Avalon-MM slave
    input  wire logic [3:0]   address,          // Byte address
    input  wire logic         read,             // Read request
    input  wire logic         write,            // Write request
    input  wire logic [31:0]  writedata,        // Write data
    input  wire logic [3:0]   byteenable,       // Byte lanes of a write
    output logic      [31:0]  readdata,         // Read data
    output logic              waitrequest,      // Stall the master
    // Monitored clocks, asynchronous to the system clock
    input  wire logic         hsCrystalClock,   // Divided high-speed crystal clock
    input  wire logic         lsCrystalClock,   // Low-speed crystal clock
    input  wire logic         rc32kClock,       // Internal 32 kHz RC clock
    // Power state from the power unit, same clock domain
    input  wire logic         batteryOnlyMode,  // Battery-backup-only mode
    // Clock tree steering
    output clock_steer_t      clockSteer,       // Crystal, PLL and source select
    // Events
    output logic              nmiEvent,         // High-speed failure, one-cycle pulse
    output logic              irq               // Level interrupt request
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        clock_control_t control;
        logic [1:0]     flags;
        logic [1:0]     mask;
        logic [7:0]     hsTimer;
        logic [3:0]     lsCount;
        logic           ack;
        logic [31:0]    readData;
        logic           nmiPulse;
    } monitor_state_t;

    monitor_state_t state;
    monitor_state_t next_state;

    logic hsEdge;
    logic lsEdge;
    logic rcEdge;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronised edges of the monitored clocks

    edge_sync hsSync (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  (hsCrystalClock),
        .rising (hsEdge)
    );

    edge_sync lsSync (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  (lsCrystalClock),
        .rising (lsEdge)
    );

    edge_sync rcSync (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  (rc32kClock),
        .rising (rcEdge)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        request;
    logic        accept;
    logic        writeControl;
    logic        writeInterrupt;
    logic        writeMask;
    logic [31:0] laneMask;
    logic [31:0] writeValue;
    logic [31:0] controlWord;
    logic [31:0] stateWord;
    logic [31:0] readValue;

    // One wait state: the first cycle of a request stalls, the second completes
    assign request        = read | write;
    assign accept         = request & state.ack;
    assign writeControl   = accept & write & (address == CONTROL_OFFSET);
    assign writeInterrupt = accept & write & (address == INTERRUPT_OFFSET);
    assign writeMask      = accept & write & (address == MASK_OFFSET);

    // Expand byte enables to bit lanes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            laneMask[i*8 +: 8] = {8{byteenable[i]}};
        end
    end

    assign writeValue = writedata & laneMask;

    // Control register image
    always_comb begin
        controlWord                            = '0;
        controlWord[HS_MON_EN_BIT]             = state.control.hsMonitorEnable;
        controlWord[LS_MON_EN_BIT]             = state.control.lsMonitorEnable;
        controlWord[HS_XTAL_EN_BIT]            = state.control.hsCrystalEnable;
        controlWord[PLL_EN_BIT]                = state.control.pllEnable;
        controlWord[SYS_SEL_LSB +: 2]          = state.control.systemClockSelect;
        controlWord[PLL_SRC_BIT]               = state.control.pllFromCrystal;
    end

    // Live counters for software
    always_comb begin
        stateWord                              = '0;
        stateWord[LS_COUNT_LSB +: 4]           = state.lsCount;
        stateWord[HS_TIMER_LSB +: 8]           = state.hsTimer;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        unique case (address)
            CONTROL_OFFSET:   readValue = controlWord;
            INTERRUPT_OFFSET: readValue = {30'h_0000_0000, state.flags};
            MASK_OFFSET:      readValue = {30'h_0000_0000, state.mask};
            STATE_OFFSET:     readValue = stateWord;
            default:          readValue = READ_DATA_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Supervision

    logic hsWatching;
    logic hsFail;
    logic hsFeedsTree;
    logic lsWatching;
    logic lsFail;
    logic [1:0] events;
    logic [1:0] clearBits;

    // High-speed watch only while enabled and the crystal is running
    assign hsWatching = state.control.hsMonitorEnable
                      & state.control.hsCrystalEnable;

    // No crystal edge within the timeout window means a stuck oscillator
    assign hsFail = hsWatching & ~hsEdge & (state.hsTimer == HS_TIMEOUT_LAST);

    // Crystal feeds the tree directly or through the PLL
    assign hsFeedsTree = (state.control.systemClockSelect == SYS_HS_CRYSTAL)
                       | (state.control.pllEnable & state.control.pllFromCrystal);

    // Low-speed watch is off in battery-only mode
    assign lsWatching = state.control.lsMonitorEnable & ~batteryOnlyMode;

    // Overflow: a sixteenth RC edge with no crystal edge since the last clear
    assign lsFail = lsWatching & rcEdge & ~lsEdge
                  & (state.lsCount == LS_COUNT_LAST);

    assign events    = {lsFail, hsFail};
    assign clearBits = writeInterrupt ? writeValue[1:0] : 2'h_0;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state          = state;
        next_state.nmiPulse = 1'b0;

        // Bus handshake and read capture
        next_state.ack = request & ~state.ack;
        if (request & ~state.ack) begin
            next_state.readData = readValue;
        end

        // Software writes to control
        if (writeControl) begin
            if (byteenable[0]) begin
                next_state.control.hsMonitorEnable   = writedata[HS_MON_EN_BIT];
                next_state.control.lsMonitorEnable   = writedata[LS_MON_EN_BIT];
                next_state.control.hsCrystalEnable   = writedata[HS_XTAL_EN_BIT];
                next_state.control.pllEnable         = writedata[PLL_EN_BIT];
                next_state.control.pllFromCrystal    = writedata[PLL_SRC_BIT];
                if (writedata[SYS_SEL_LSB +: 2] != 2'h_3) begin
                    next_state.control.systemClockSelect =
                        system_source_t'(writedata[SYS_SEL_LSB +: 2]);
                end
            end
        end

        // Mask register
        if (writeMask) begin
            next_state.mask = writeValue[1:0];
        end

        // Sticky flags: a new event wins over a write-one clear
        next_state.flags = (state.flags & ~clearBits) | events;

        // High-speed timer restarts on every crystal edge
        if (!hsWatching || hsEdge) begin
            next_state.hsTimer = HS_TIMEOUT_RESET_VALUE();
        end else if (!hsFail) begin
            next_state.hsTimer = state.hsTimer + 8'h_01;
        end

        // High-speed failure overrides a same-cycle software write of the crystal, PLL and source bits it sets
        if (hsFail) begin
            next_state.hsTimer                 = HS_TIMER_RESET;
            next_state.control.hsCrystalEnable = 1'b0;
            next_state.nmiPulse                = 1'b1;
            if (hsFeedsTree) begin
                next_state.control.systemClockSelect = SYS_RC16M;
                next_state.control.pllEnable         = 1'b0;
            end
        end

        // Low-speed counter steps on RC edges, cleared by crystal edges
        if (!lsWatching || lsEdge) begin
            next_state.lsCount = LS_COUNT_RESET;
        end else if (rcEdge) begin
            next_state.lsCount = state.lsCount + 4'h_1;
        end
    end

    // Reset value of the high-speed timer
    function automatic logic [7:0] HS_TIMEOUT_RESET_VALUE();
        return HS_TIMER_RESET;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state.control  <= CONTROL_RESET;
            state.flags    <= FLAGS_RESET;
            state.mask     <= MASK_RESET;
            state.hsTimer  <= HS_TIMER_RESET;
            state.lsCount  <= LS_COUNT_RESET;
            state.ack      <= 1'b0;
            state.readData <= READ_DATA_RESET;
            state.nmiPulse <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Bus answer
    assign waitrequest = request & ~state.ack;
    assign readdata    = state.readData;

    // Clock tree steering
    assign clockSteer.hsCrystalEnable   = state.control.hsCrystalEnable;
    assign clockSteer.pllEnable         = state.control.pllEnable;
    assign clockSteer.systemClockSelect = state.control.systemClockSelect;

    // High-speed failure event to the non-maskable input
    assign nmiEvent = state.nmiPulse;

    // Masked interrupt level, low-speed failure included
    assign irq = |(state.flags & state.mask);

endmodule // crystal_clock_failure_monitor

// ==== hw/clock_monitor_pkg.sv ====
package clock_monitor_pkg;

    // Clock rate and timing
    localparam int          CLOCK_PERIOD_NS    = 50;
    localparam int          HS_TIMEOUT_NS      = 3200;
    localparam int          HS_TIMEOUT_CYCLES  = (HS_TIMEOUT_NS + CLOCK_PERIOD_NS - 1)
                                                 / CLOCK_PERIOD_NS;
    localparam logic [7:0]  HS_TIMEOUT_LAST    = 8'(HS_TIMEOUT_CYCLES - 1);
    localparam int          LS_COUNT_WIDTH     = 4;
    localparam logic [3:0]  LS_COUNT_LAST      = 4'h_f;

    // Register byte addresses on the word-aligned bus
    localparam logic [3:0]  CONTROL_OFFSET     = 4'h_0;
    localparam logic [3:0]  INTERRUPT_OFFSET   = 4'h_4;
    localparam logic [3:0]  MASK_OFFSET        = 4'h_8;
    localparam logic [3:0]  STATE_OFFSET       = 4'h_c;

    // Control register field positions
    localparam int          HS_MON_EN_BIT      = 0;
    localparam int          LS_MON_EN_BIT      = 1;
    localparam int          HS_XTAL_EN_BIT     = 2;
    localparam int          PLL_EN_BIT         = 3;
    localparam int          SYS_SEL_LSB        = 4;
    localparam int          PLL_SRC_BIT        = 6;

    // Interrupt and mask register field positions
    localparam int          HS_STUCK_BIT       = 0;
    localparam int          LS_FAIL_BIT        = 1;

    // State register field positions
    localparam int          LS_COUNT_LSB       = 0;
    localparam int          HS_TIMER_LSB       = 8;

    // Reset values
    localparam logic [1:0]  FLAGS_RESET        = 2'h_0;
    localparam logic [1:0]  MASK_RESET         = 2'h_0;
    localparam logic [7:0]  HS_TIMER_RESET     = 8'h_00;
    localparam logic [3:0]  LS_COUNT_RESET     = 4'h_0;
    localparam logic [31:0] READ_DATA_RESET    = 32'h_0000_0000;

    // System clock source selection
    typedef enum logic [1:0] {
        SYS_RC16M,
        SYS_HS_CRYSTAL,
        SYS_PLL
    } system_source_t;

    // Software-visible clock control bits
    typedef struct packed {
        logic           pllFromCrystal;
        system_source_t systemClockSelect;
        logic           pllEnable;
        logic           hsCrystalEnable;
        logic           lsMonitorEnable;
        logic           hsMonitorEnable;
    } clock_control_t;

    localparam clock_control_t CONTROL_RESET = '{
        pllFromCrystal:    1'b0,
        systemClockSelect: SYS_RC16M,
        pllEnable:         1'b0,
        hsCrystalEnable:   1'b0,
        lsMonitorEnable:   1'b0,
        hsMonitorEnable:   1'b0
    };

    // Clock steering outputs toward the clock tree
    typedef struct packed {
        logic           hsCrystalEnable;
        logic           pllEnable;
        system_source_t systemClockSelect;
    } clock_steer_t;

endpackage : clock_monitor_pkg

// ==== hw/edge_sync.sv ====
module edge_sync
    import clock_monitor_pkg::*;
(
    input  wire logic clock,    // System clock
    input  wire logic rst_n,    // Asynchronous reset, active low
    input  wire logic pinIn,    // Asynchronous level from a pin
    output logic      rising    // One-cycle pulse on a rising edge
);

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // Two-stage synchroniser, then a delayed copy for the edge
    always_comb begin
        next_state        = state;
        next_state.stage1 = pinIn;
        next_state.stage2 = state.stage1;
        next_state.stage3 = state.stage2;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Edge taken only from the second and third stages
    assign rising = state.stage2 & ~state.stage3;

endmodule // edge_sync

// ==== verification/crystal_clock_failure_monitor_props.sv ====
module crystal_clock_failure_monitor_props
    import clock_monitor_pkg::*;
(
    input wire logic         clock,          // System clock
    input wire logic         rst_n,          // Reset, active low
    input wire logic         read,           // Read request
    input wire logic         write,          // Write request
    input wire logic [31:0]  readdata,       // Read data
    input wire logic         waitrequest,    // Bus stall
    input wire logic         hsCrystalClock, // Crystal pin
    input wire clock_steer_t clockSteer,     // Clock steering
    input wire logic         nmiEvent,       // Failure event
    input wire logic         irq             // Interrupt
);
    logic       hsPrev;
    logic [7:0] hsQuiet;

    ////////////////////////////////////////////////////////////////
    // Cycles since the crystal pin last rose
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hsPrev  <= 1'b0;
            hsQuiet <= 8'h_00;
        end else begin
            hsPrev  <= hsCrystalClock;
            hsQuiet <= (hsCrystalClock && !hsPrev) ? 8'h_00 : hsQuiet + 8'(hsQuiet != 8'h_ff);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_req_wait; (read || write) && waitrequest; endsequence
    sequence s_idle; !read && !write; endsequence
    sequence s_no_write; !(write && !waitrequest); endsequence
    property p_one_wait; s_req_wait |=> !waitrequest; endproperty
    property p_read_hold; s_idle |=> $stable(readdata); endproperty
    property p_nmi_pulse; nmiEvent |=> !nmiEvent; endproperty
    property p_nmi_off;
        nmiEvent |-> !clockSteer.hsCrystalEnable && $past(clockSteer.hsCrystalEnable, 2);
    endproperty
    property p_nmi_quiet; nmiEvent |-> hsQuiet >= 8'h_3c; endproperty
    property p_fallback;
        nmiEvent && $past(clockSteer.systemClockSelect, 2) == SYS_HS_CRYSTAL
            |-> clockSteer.systemClockSelect == SYS_RC16M && !clockSteer.pllEnable;
    endproperty
    property p_irq_sticky; irq && !(write && !waitrequest) |=> irq; endproperty
    property p_steer_auto; s_no_write ##1 $changed(clockSteer) |-> nmiEvent; endproperty
    a_one_wait: assert property (p_one_wait) else $error("More than one wait state");
    a_read_hold: assert property (p_read_hold) else $error("Read data moved while idle");
    a_nmi_pulse: assert property (p_nmi_pulse) else $error("Event longer than a cycle");
    a_nmi_off: assert property (p_nmi_off) else $error("Crystal not switched off");
    a_nmi_quiet: assert property (p_nmi_quiet) else $error("Alarm on a live crystal");
    a_fallback: assert property (p_fallback) else $error("No fallback to RC");
    a_irq_sticky: assert property (p_irq_sticky) else $error("Flag dropped by itself");
    a_steer_auto: assert property (p_steer_auto) else $error("Steering moved alone");
endmodule // crystal_clock_failure_monitor_props

bind crystal_clock_failure_monitor crystal_clock_failure_monitor_props checker_u (
    .clock(clock), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .hsCrystalClock(hsCrystalClock), .clockSteer(clockSteer),
    .nmiEvent(nmiEvent), .irq(irq));

// ==== verification/crystal_partner.sv ====
module crystal_partner (
    input  wire logic crystalOn, // Crystal enabled by the device
    input  wire logic hsStall,   // Freeze the fast crystal
    input  wire logic lsStall,   // Freeze the slow crystal
    output logic      hsClk,     // Divided fast crystal
    output logic      lsClk,     // Slow crystal
    output logic      rcClk      // Internal slow RC
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////
    // Oscillators; a stalled one sticks at its last level
    initial begin
        hsClk = 1'b0;
        lsClk = 1'b0;
        rcClk = 1'b0;
    end
    always #750 if (crystalOn === 1'b1 && !hsStall) hsClk = ~hsClk;
    always #950 if (!lsStall) lsClk = ~lsClk;
    always #1000 rcClk = ~rcClk;
endmodule // crystal_partner

// ==== verification/crystal_clock_failure_monitor_test.sv ====
module crystal_clock_failure_monitor_test
    import clock_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic [3:0]   address = 4'h_0;
    logic         read = 1'b0;
    logic         write = 1'b0;
    logic [31:0]  writedata = 32'h_0000_0000;
    logic         batteryOnlyMode = 1'b0;
    logic         hsStall = 1'b0;
    logic         lsStall = 1'b0;
    logic [31:0]  readdata, rd;
    logic         waitrequest, hsCrystalClock, lsCrystalClock, rc32kClock, nmiEvent, irq;
    clock_steer_t clockSteer;
    int           fail_count = 0, comparisons = 0, cycles = 0, nmiCount = 0, n;

    always #25 clock = ~clock;

    crystal_clock_failure_monitor dut_u (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h_f), .readdata(readdata),
        .waitrequest(waitrequest), .hsCrystalClock(hsCrystalClock),
        .lsCrystalClock(lsCrystalClock), .rc32kClock(rc32kClock),
        .batteryOnlyMode(batteryOnlyMode), .clockSteer(clockSteer), .nmiEvent(nmiEvent),
        .irq(irq));
    crystal_partner partner_u (
        .crystalOn(clockSteer.hsCrystalEnable), .hsStall(hsStall), .lsStall(lsStall),
        .hsClk(hsCrystalClock), .lsClk(lsCrystalClock), .rcClk(rc32kClock));

    ////////////////////////////////////////////////////////////////
    // Reporting and bus tasks
    task close_out;
        $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address   <= a;
        writedata <= d;
        write     <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read    <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // Reset values and an unmapped place
    task t_reset;
        logic [3:0] offs[4] = '{CONTROL_OFFSET, INTERRUPT_OFFSET, MASK_OFFSET, 4'h_2};
        check(32'(clockSteer), 32'h_0000_0000, "steering after reset");
        bus_write(4'h_2, 32'h_ffff_ffff);
        for (int i = 0; i < 4; i++) begin
            bus_read(offs[i], rd);
            check(rd, 32'h_0000_0000, "register after reset");
        end
        $display("t_reset done");
    endtask

    ////////////////////////////////////////////////////////////////
    // Fast crystal failure under three clock setups
    task t_hs;
        logic [31:0] ctl[3] = '{32'h_0000_0015, 32'h_0000_006d, 32'h_0000_002d};
        logic [31:0] after[3] = '{32'h_0000_0000, 32'h_0000_0000, 32'h_0000_0006};
        bus_write(MASK_OFFSET, 32'h_0000_0001);
        bus_write(CONTROL_OFFSET, 32'h_0000_0014);
        hsStall <= 1'b1;
        repeat (150) @(posedge clock);
        check(nmiCount, 0, "alarm with monitor off");
        check(32'(clockSteer), 32'h_0000_0009, "steering with monitor off");
        for (int i = 0; i < 3; i++) begin
            hsStall <= 1'b0;
            bus_write(CONTROL_OFFSET, ctl[i] & 32'h_ffff_fffe);
            repeat (100) @(posedge clock);
            bus_write(CONTROL_OFFSET, ctl[i]);
            repeat (200) @(posedge clock);
            check(nmiCount, i, "alarm on live crystal");
            hsStall <= 1'b1;
            n = 0;
            while (nmiCount == i && n < 200) begin
                @(posedge clock);
                n++;
            end
            check(nmiCount, i + 1, "no crystal alarm");
            check(32'(n >= 34), 1, "alarm too early");
            check(32'(clockSteer), after[i], "fallback steering");
            check(32'(irq), 1, "stuck interrupt");
            bus_read(INTERRUPT_OFFSET, rd);
            check(rd & 32'h_0000_0003, 32'h_0000_0001, "stuck flag");
            bus_write(INTERRUPT_OFFSET, 32'h_0000_0001);
            @(posedge clock);
            check(32'(irq), 0, "flag clear");
            check(32'(clockSteer), after[i], "crystal restarted");
        end
        bus_write(CONTROL_OFFSET, 32'h_0000_0000);
        $display("t_hs done");
    endtask

    ////////////////////////////////////////////////////////////////
    // Slow crystal supervision, battery mode and failure
    task t_ls;
        bus_write(MASK_OFFSET, 32'h_0000_0002);
        bus_write(CONTROL_OFFSET, 32'h_0000_0002);
        repeat (2000) @(posedge clock);
        check(32'(irq), 0, "slow alarm on live crystal");
        bus_read(STATE_OFFSET, rd);
        check(32'(rd[3:0] <= 4'h_2), 1, "slow count not cleared");
        batteryOnlyMode <= 1'b1;
        lsStall <= 1'b1;
        repeat (1000) @(posedge clock);
        check(32'(irq), 0, "alarm in battery mode");
        bus_read(STATE_OFFSET, rd);
        check(rd & 32'h_0000_000f, 32'h_0000_0000, "count in battery mode");
        batteryOnlyMode <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 900) begin
            @(posedge clock);
            n++;
        end
        check(32'(n >= 560 && n < 900), 1, "slow alarm timing");
        bus_read(INTERRUPT_OFFSET, rd);
        check(rd & 32'h_0000_0003, 32'h_0000_0002, "slow flag");
        bus_write(MASK_OFFSET, 32'h_0000_0000);
        @(posedge clock);
        check(32'(irq), 0, "masked interrupt");
        bus_write(CONTROL_OFFSET, 32'h_0000_0000);
        bus_write(INTERRUPT_OFFSET, 32'h_0000_0002);
        bus_read(INTERRUPT_OFFSET, rd);
        check(rd & 32'h_0000_0003, 32'h_0000_0000, "slow flag clear");
        $display("t_ls done");
    endtask

    ////////////////////////////////////////////////////////////////
    // Cycle guard and event tally
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (nmiEvent === 1'b1) nmiCount <= nmiCount + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_hs();
        t_ls();
        close_out();
    end
endmodule // crystal_clock_failure_monitor_test
